// File: tb/motor_pwm_adc_sequencer_bench.sv
`timescale 1ns/1ps

module motor_pwm_adc_sequencer_bench;
  import mpa_pkg::*;
  // small counts keep the run short; dead time still fits inside each duty phase
  localparam int PEAK = 300;
  localparam int IVAL = 40;
  logic        i_clk, i_reset_n, i_clk_en, i_trip_clear, i_output_enable, i_result_rd;
  logic [15:0] i_duty_u, i_duty_v, i_duty_w, o_result_data;
  logic [2:0]  i_result_sel, o_pwm_hi, o_pwm_lo, o_conv_channel, o_scan_end_priority;
  logic [5:0]  o_pwm_oe;
  logic        o_trip_status, o_conv_start, o_scan_busy, o_scan_end, o_result_valid, o_speed_tick;
  logic        trip_n, conv_done, slow, fault, mtrip, en_q;
  logic [11:0] conv_data, sample;
  logic [2:0]  prev_hi, prev_lo, armed;
  int          seed, error_cnt, checked, cyc, idx, done_cyc, last_first, tick_cyc, scans, n;
  int          exp[8];
  int          gap[3];

  mpa_core #(.P_PWM_PEAK(PEAK), .P_INTERVAL_CYCLES(IVAL)) DUT (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en), .i_duty_u(i_duty_u), .i_duty_v(i_duty_v),
    .i_duty_w(i_duty_w), .i_overcurrent_trip_input_n(trip_n), .i_trip_clear(i_trip_clear),
    .i_output_enable(i_output_enable), .i_conv_done(conv_done), .i_conv_data(conv_data),
    .i_result_rd(i_result_rd), .i_result_sel(i_result_sel), .o_pwm_hi(o_pwm_hi), .o_pwm_lo(o_pwm_lo),
    .o_pwm_oe(o_pwm_oe), .o_trip_status(o_trip_status), .o_conv_start(o_conv_start),
    .o_conv_channel(o_conv_channel), .o_scan_busy(o_scan_busy), .o_scan_end(o_scan_end),
    .o_scan_end_priority(o_scan_end_priority), .o_result_data(o_result_data),
    .o_result_valid(o_result_valid), .o_speed_tick(o_speed_tick));

  mpa_power_stage stage (
    .i_clk(i_clk), .i_conv_start(o_conv_start), .i_slow(slow), .i_fault(fault), .i_sample(sample),
    .o_conv_done(conv_done), .o_conv_data(conv_data), .o_trip_n(trip_n));

  function automatic bit ok(input logic c);
    checked++;
    return c === 1'b1;
  endfunction : ok

  task automatic fail(input string m);
    error_cnt++;
    $display("BAD %0t %s", $time, m);
  endtask : fail

  task automatic complete_run;
    if (error_cnt == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  // back-to-back reads: the strobe stays up between calls and the caller drops it
  task automatic rd(input logic [2:0] s);
    int e;
    e = (s < 3'h6) ? exp[s] : 0;
    i_result_sel = s;
    i_result_rd  = 1'b1;
    @(negedge i_clk);
    if (!ok(o_result_data === 16'(e) && (s > 3'h5 || o_result_valid === 1'b1))) fail("result read");
    if (s < 3'h6) exp[s] = 0;
  endtask : rd

  task automatic wait_scan;
    n = scans;
    for (int k = 0; k < 2000 && scans == n; k++) @(negedge i_clk);
    if (!ok(scans != n)) fail("scan never ended");
  endtask : wait_scan

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  always @(negedge i_clk) sample <= 12'($random(seed));

  // ----------------------------------------
  // reference model, compared every cycle
  // ----------------------------------------
  always @(posedge i_clk) begin
    cyc++;
    if (!i_reset_n) begin
      mtrip   = 1'b0;
      en_q    = 1'b0;
      idx     = 0;
      prev_hi = 3'h0;
      prev_lo = 3'h0;
      armed   = 3'h0;
    end else begin
      if (!ok(o_trip_status === mtrip && o_pwm_oe === {6{~mtrip & en_q}})) fail("trip or enable state");
      mtrip = !trip_n ? 1'b1 : (i_trip_clear ? 1'b0 : mtrip);
      en_q  = i_output_enable;
      if (o_conv_start) begin
        if (!ok(o_conv_channel === idx[2:0] && idx < SCAN_LEN)) fail("channel order");
        if (!ok(o_scan_busy === 1'b1)) fail("busy during scan");
        if (idx > 0 && !ok(cyc - done_cyc == 2)) fail("start after done");
        if (idx == 0 && last_first > 0 && !ok(cyc - last_first == 2 * PEAK)) fail("trigger");
        if (idx == 0) last_first = cyc;
        idx++;
      end
      if (conv_done && idx > 0) begin
        exp[idx-1] = int'(conv_data);
        done_cyc   = cyc;
      end
      if (o_scan_end) begin
        if (!ok(idx == 6 && cyc - done_cyc == 1 && o_scan_end_priority === 3'h5)) fail("scan end");
        if (!ok(o_scan_busy === 1'b0)) fail("busy after scan end");
        idx = 0;
        scans++;
      end
      if (o_speed_tick) begin
        if (tick_cyc > 0 && !ok(cyc - tick_cyc == IVAL)) fail("interval tick");
        tick_cyc = cyc;
      end
      for (int p = 0; p < 3; p++) begin
        if (!ok(!(o_pwm_hi[p] && o_pwm_lo[p]))) fail("both pins on");
        if (armed[p] && (o_pwm_hi[p] | o_pwm_lo[p]) && !(prev_hi[p] | prev_lo[p])) begin
          if (!ok(gap[p] == 200)) fail("dead time length");
          armed[p] = 1'b0;
        end
        if ((prev_hi[p] & ~o_pwm_hi[p]) | (prev_lo[p] & ~o_pwm_lo[p])) begin
          armed[p] = 1'b1;
          gap[p]   = 1;
        end else if (!o_pwm_hi[p] && !o_pwm_lo[p]) gap[p]++;
      end
      prev_hi = o_pwm_hi;
      prev_lo = o_pwm_lo;
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h1bc5_0ea3;
    {i_reset_n, i_trip_clear, i_result_rd, slow, fault} = 5'h00;
    {i_clk_en, i_output_enable, i_result_sel} = 5'h18;
    // random duties, each phase level longer than the dead time
    i_duty_u = 16'(110 + (($random(seed) & 32'h7fff_ffff) % 81));
    i_duty_v = 16'(110 + (($random(seed) & 32'h7fff_ffff) % 81));
    i_duty_w = 16'(110 + (($random(seed) & 32'h7fff_ffff) % 81));
    repeat (3) @(negedge i_clk);
    if (!ok(o_scan_end_priority === 3'h5 && o_pwm_oe === 6'h00 && o_conv_start === 1'b0)) fail("reset");
    i_reset_n = 1'b1;
    for (int s = 0; s < 4; s++) begin
      slow = s[0];
      wait_scan();
      for (int r = 0; r < 14; r++) rd(3'(r % 8));
      i_result_rd = 1'b0;
    end
    fault = 1'b1;
    repeat (2) @(negedge i_clk);
    fault = 1'b0;
    repeat (5) @(negedge i_clk);
    if (!ok(o_pwm_oe === 6'h00 && o_trip_status === 1'b1)) fail("trip not held");
    fault        = 1'b1;
    i_trip_clear = 1'b1;
    @(negedge i_clk);
    fault        = 1'b0;
    i_trip_clear = 1'b0;
    repeat (2) @(negedge i_clk);
    if (!ok(o_pwm_oe === 6'h00)) fail("clear during trip");
    i_trip_clear = 1'b1;
    @(negedge i_clk);
    i_trip_clear = 1'b0;
    if (!ok(o_pwm_oe === 6'h3f && o_trip_status === 1'b0)) fail("clear and re-enable");
    wait_scan();
    i_output_enable = 1'b0;
    repeat (2) @(negedge i_clk);
    if (!ok(o_pwm_oe === 6'h00)) fail("output enable low");
    complete_run();
  end

  initial begin
    #(40 * 20000);
    fail("timeout");
    complete_run();
  end
endmodule : motor_pwm_adc_sequencer_bench

// File: tb/mpa_power_stage.sv
`timescale 1ns/1ps

// ----------------------------------------
// inverter stage and current sensing model
// ----------------------------------------
module mpa_power_stage (
  input  wire logic        i_clk,
  input  wire logic        i_conv_start,
  input  wire logic        i_slow,
  input  wire logic        i_fault,
  input  wire logic [11:0] i_sample,
  output logic             o_conv_done,
  output logic [11:0]      o_conv_data,
  output logic             o_trip_n
);
  int wait_cnt;

  initial begin
    o_conv_done = 1'b0;
    o_conv_data = 12'h0a5a;
    wait_cnt    = -1;
  end

  // trip line is pulled up, the stage pulls it low on overcurrent
  assign o_trip_n = ~i_fault;

  // answers each start promptly or slowly; the data line inverts every cycle and carries the sample only in the done cycle
  always @(negedge i_clk) begin
    o_conv_done <= 1'b0;
    o_conv_data <= ~o_conv_data;
    if (wait_cnt == 0) begin
      o_conv_done <= 1'b1;
      o_conv_data <= i_sample;
    end
    if (wait_cnt >= 0) wait_cnt <= wait_cnt - 1;
    if (i_conv_start) wait_cnt <= i_slow ? 7 : 0;
  end
endmodule : mpa_power_stage

// File: verilog/mpa_core.sv
`timescale 1ns/1ps

module mpa_core
  import mpa_pkg::*;
#(
  parameter int P_PWM_PEAK       = PWM_PEAK_COUNTS,
  parameter int P_INTERVAL_CYCLES = INTERVAL_CYCLES
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_reset_n,
  input  wire logic                   i_clk_en,
  input  wire logic [15:0]            i_duty_u,
  input  wire logic [15:0]            i_duty_v,
  input  wire logic [15:0]            i_duty_w,
  input  wire logic                   i_overcurrent_trip_input_n,
  input  wire logic                   i_trip_clear,
  input  wire logic                   i_output_enable,
  input  wire logic                   i_conv_done,
  input  wire logic [CONV_BITS-1:0]   i_conv_data,
  input  wire logic                   i_result_rd,
  input  wire logic [2:0]             i_result_sel,
  output logic [2:0]                  o_pwm_hi,
  output logic [2:0]                  o_pwm_lo,
  output logic [5:0]                  o_pwm_oe,
  output logic                        o_trip_status,
  output logic                        o_conv_start,
  output logic [2:0]                  o_conv_channel,
  output logic                        o_scan_busy,
  output logic                        o_scan_end,
  output logic [2:0]                  o_scan_end_priority,
  output logic [RESULT_BITS-1:0]      o_result_data,
  output logic                        o_result_valid,
  output logic                        o_speed_tick
);
  typedef enum logic [1:0] {SC_IDLE, SC_START, SC_WAIT} mpa_scan_t;

  logic [15:0]            pwm_cnt;
  logic                   pwm_up;
  logic                   underflow;
  logic [2:0]             hi_w;
  logic [2:0]             lo_w;
  logic                   trip;
  mpa_scan_t              scan_st;
  logic [2:0]             scan_ch;
  logic [RESULT_BITS-1:0] result_mem [SCAN_LEN];
  logic [15:0]            int_cnt;

  // ----------------------------------------
  // pwm timer channel one carrier
  // ----------------------------------------
  wire        pwm_at_peak    = (pwm_cnt == 16'(P_PWM_PEAK - 1));
  wire        next_underflow = !pwm_up && (pwm_cnt == 16'h0001);
  wire [15:0] next_pwm_cnt   = pwm_up ? pwm_cnt + 16'h0001 : pwm_cnt - 16'h0001;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pwm_cnt   <= 16'h0000;
      pwm_up    <= 1'b1;
      underflow <= 1'b0;
    end else if (i_clk_en) begin
      pwm_cnt   <= next_pwm_cnt;
      underflow <= next_underflow;
      if (pwm_up && pwm_at_peak) begin
        pwm_up <= 1'b0;
      end else if (next_underflow) begin
        pwm_up <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // complementary pairs
  // ----------------------------------------
  wire [15:0] duty [3];
  assign duty[0] = i_duty_u;
  assign duty[1] = i_duty_v;
  assign duty[2] = i_duty_w;

  for (genvar g = 0; g < 3; g++) begin : g_phase
    mpa_dead_time u_dead (
      .i_clk      (i_clk),
      .i_reset_n  (i_reset_n),
      .i_clk_en   (i_clk_en),
      .i_ref      (pwm_cnt < duty[g]),
      .i_count_up (pwm_up),
      .o_hi       (hi_w[g]),
      .o_lo       (lo_w[g])
    );
  end

  // ----------------------------------------
  // output disable
  // ----------------------------------------
  // trip latch, set wins over clear
  wire trip_seen = !i_overcurrent_trip_input_n;
  wire next_trip = trip_seen || (trip && !i_trip_clear);
  wire next_oe   = !next_trip && i_output_enable;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      trip          <= 1'b0;
      o_trip_status <= 1'b0;
      o_pwm_oe      <= 6'h00;
      o_pwm_hi      <= 3'h0;
      o_pwm_lo      <= 3'h0;
    end else if (i_clk_en) begin
      trip          <= next_trip;
      o_trip_status <= next_trip;
      o_pwm_oe      <= {6{next_oe}};
      o_pwm_hi      <= hi_w;
      o_pwm_lo      <= lo_w;
    end
  end

  // ----------------------------------------
  // single scan sequencer
  // ----------------------------------------
  // only the carrier underflow starts a scan
  wire scan_go   = (scan_st == SC_IDLE) && underflow;
  wire conv_take = (scan_st == SC_WAIT) && i_conv_done;
  wire scan_last = conv_take && (scan_ch == SCAN_LAST);

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      scan_st             <= SC_IDLE;
      scan_ch             <= 3'h0;
      o_conv_start        <= 1'b0;
      o_conv_channel      <= 3'h0;
      o_scan_busy         <= 1'b0;
      o_scan_end          <= 1'b0;
      o_scan_end_priority <= SCAN_END_PRIORITY;
    end else if (i_clk_en) begin
      o_conv_start <= 1'b0;
      o_scan_end   <= scan_last;
      case (scan_st)
        SC_IDLE: begin
          if (scan_go) begin
            scan_ch     <= CH_CUR_U;
            o_scan_busy <= 1'b1;
            scan_st     <= SC_START;
          end
        end
        SC_START: begin
          o_conv_start   <= 1'b1;
          o_conv_channel <= scan_ch;
          scan_st        <= SC_WAIT;
        end
        SC_WAIT: begin
          if (scan_last) begin
            o_scan_busy <= 1'b0;
            scan_st     <= SC_IDLE;
          end else if (conv_take) begin
            scan_ch <= scan_ch + 3'h1;
            scan_st <= SC_START;
          end
        end
        default: scan_st <= SC_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // result store, cleared on read
  // ----------------------------------------
  // right-aligned 12-bit value
  wire [RESULT_BITS-1:0] conv_word = {{(RESULT_BITS-CONV_BITS){1'b0}}, i_conv_data};
  wire                   rd_ok     = i_result_rd && (i_result_sel < 3'(SCAN_LEN));

  for (genvar e = 0; e < SCAN_LEN; e++) begin : g_result
    wire wr_hit = conv_take && (scan_ch == 3'(e));
    wire rd_hit = rd_ok && (i_result_sel == 3'(e));
    // a fresh result beats a clear in the same cycle
    always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
        result_mem[e] <= RESULT_RESET;
      end else if (i_clk_en) begin
        if (wr_hit) begin
          result_mem[e] <= conv_word;
        end else if (rd_hit) begin
          result_mem[e] <= RESULT_RESET;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_result_data  <= RESULT_RESET;
      o_result_valid <= 1'b0;
    end else if (i_clk_en) begin
      o_result_valid <= i_result_rd;
      o_result_data  <= rd_ok ? result_mem[i_result_sel] : RESULT_RESET;
    end
  end

  // ----------------------------------------
  // speed loop interval timer
  // ----------------------------------------
  // periodic tick
  wire int_wrap = (int_cnt == 16'(P_INTERVAL_CYCLES - 1));

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      int_cnt      <= 16'h0000;
      o_speed_tick <= 1'b0;
    end else if (i_clk_en) begin
      int_cnt      <= int_wrap ? 16'h0000 : int_cnt + 16'h0001;
      o_speed_tick <= int_wrap;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_NO_SOFT_START: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_clk_en && scan_st == SC_IDLE && !underflow) |=> scan_st == SC_IDLE)
    else $error("scan left idle without a trigger");
  AST_UNDERFLOW_START: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_clk_en && scan_go) |=> (scan_st == SC_START && scan_ch == 3'h0 && o_scan_busy))
    else $error("underflow did not start a scan");
  AST_SIX_INPUTS: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(o_scan_end) |-> $past(scan_ch) == SCAN_LAST && !o_scan_busy)
    else $error("scan ended at wrong input");
  AST_READ_CLEARS: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_clk_en && rd_ok && !conv_take) |=> result_mem[$past(i_result_sel)] == RESULT_RESET)
    else $error("result not cleared after read");
  AST_RIGHT_ALIGN: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_result_data[RESULT_BITS-1:CONV_BITS] == '0)
    else $error("result not right aligned");
  AST_SCAN_END_PRIO: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_scan_end |-> (o_scan_end_priority == 3'h5 && $past(conv_take)))
    else $error("scan end without last conversion");
  AST_TICK_PERIOD: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(o_speed_tick) |-> $past(int_cnt) == 16'(P_INTERVAL_CYCLES - 1))
    else $error("interval tick at wrong count");
  AST_TRIP_HIZ: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_clk_en && !i_overcurrent_trip_input_n) |=> (o_pwm_oe == 6'h00 && o_trip_status))
    else $error("pins driven during overcurrent");
  AST_TRIP_HOLD: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_clk_en && trip && !i_trip_clear) |=> (o_pwm_oe == 6'h00 && o_trip_status))
    else $error("pins re-enabled without clear");
endmodule : mpa_core

// File: verilog/mpa_dead_time.sv
//
// Contract
// - the converter runs one single scan per hardware trigger and then stops until the next trigger.
// - each scan samples the three phase currents, the bus voltage, the position sensor and the speed command.
// - results are 12-bit, stored right-aligned, and a result is cleared when it is read.
// - the only scan trigger is the underflow of pwm_timer_channel_one, with no second group and no double trigger.
// - a completed scan raises a scan-end request that carries priority level 5.
// - a separate interval timer produces a periodic event every 500 microseconds.
// - three pwm channels each drive a complementary pair with dead time between one turning off and the other on.
// - a low level on the overcurrent trip input puts every pwm pin into high impedance.
// - the dead time is 200 timer counts both while counting up and while counting down.
`timescale 1ns/1ps

package mpa_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int          CLK_MHZ            = 25;
  localparam int          PWM_PERIOD_US      = 350;
  localparam int          PWM_PERIOD_CYCLES  = PWM_PERIOD_US * CLK_MHZ;
  localparam int          PWM_PEAK_COUNTS    = PWM_PERIOD_CYCLES / 2;
  localparam int          INTERVAL_US        = 500;
  localparam int          INTERVAL_CYCLES    = INTERVAL_US * CLK_MHZ;
  localparam logic [7:0]  DEAD_UP_COUNTS     = 8'hC8;
  localparam logic [7:0]  DEAD_DOWN_COUNTS   = 8'hC8;
  // ----------------------------------------
  // converter
  // ----------------------------------------
  localparam int          CONV_BITS          = 12;
  localparam int          RESULT_BITS        = 16;
  localparam int          SCAN_LEN           = 6;
  localparam logic [2:0]  SCAN_LAST          = 3'h5;
  localparam logic [2:0]  SCAN_END_PRIORITY  = 3'h5;
  localparam logic [15:0] RESULT_RESET       = 16'h0000;
  // scan order: phase u, v, w currents, bus voltage, position sensor, speed command
  typedef enum logic [2:0] {CH_CUR_U, CH_CUR_V, CH_CUR_W, CH_BUS_V, CH_POS, CH_SPEED} mpa_chan_t;
endpackage : mpa_pkg

module mpa_dead_time
  import mpa_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  input  wire logic i_clk_en,
  input  wire logic i_ref,
  input  wire logic i_count_up,
  output logic      o_hi,
  output logic      o_lo
);
  logic       ref_q;
  logic [7:0] dead_cnt;
  logic [8:0] off_len;
  wire        edge_seen = (i_ref != ref_q);
  wire [7:0]  dead_load = (i_count_up ? DEAD_UP_COUNTS : DEAD_DOWN_COUNTS) - 8'h01;

  // ----------------------------------------
  // dead time insertion
  // ----------------------------------------
  // both off, then delay
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ref_q    <= 1'b0;
      dead_cnt <= 8'h00;
      o_hi     <= 1'b0;
      o_lo     <= 1'b0;
    end else if (i_clk_en) begin
      if (edge_seen) begin
        ref_q    <= i_ref;
        dead_cnt <= dead_load;
        o_hi     <= 1'b0;
        o_lo     <= 1'b0;
      end else if (dead_cnt != 8'h00) begin
        dead_cnt <= dead_cnt - 8'h01;
      end else begin
        o_hi <= ref_q;
        o_lo <= ~ref_q;
      end
    end
  end

  // helper: length of the current both-off gap
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      off_len <= 9'h000;
    end else if (i_clk_en) begin
      off_len <= (o_hi || o_lo) ? 9'h000 : ((off_len == 9'h1FF) ? off_len : off_len + 9'h001);
    end
  end

  AST_NO_OVERLAP: assert property (@(posedge i_clk) disable iff (!i_reset_n) !(o_hi && o_lo))
    else $error("both outputs of a pair on");
  AST_DEAD_GAP: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_clk_en && !o_hi && !o_lo && ref_q && !edge_seen && dead_cnt == 8'h00) |-> off_len >= 9'h0C7)
    else $error("dead time shorter than 200 counts");
endmodule : mpa_dead_time
